// File: rtl/spavg_consts.vh
// constants for the sample post-processing and averaging block
`ifndef SPAVG_CONSTS_VH
`define SPAVG_CONSTS_VH
// register byte offsets
`define SPAVG_OFS_FORMAT   8'h00
`define SPAVG_OFS_AVGEXP   8'h04
`define SPAVG_OFS_OFFSET0  8'h08
`define SPAVG_OFS_OFFSET1  8'h0c
`define SPAVG_OFS_GAIN0    8'h10
`define SPAVG_OFS_GAIN1    8'h14
`define SPAVG_OFS_PATTERN  8'h18
`define SPAVG_OFS_STATUS   8'h1c
`define SPAVG_OFS_RESULT0  8'h20
`define SPAVG_OFS_RESULT1  8'h24
// reset values
`define SPAVG_RST_FORMAT   3'h0
`define SPAVG_RST_AVGEXP   5'h00
`define SPAVG_RST_OFFSET   16'h0000
`define SPAVG_RST_GAIN     16'h8000
`define SPAVG_RST_PATTERN  32'h5a5a0f0f
// output format selector codes
`define SPAVG_FMT_DIFF     3'h0
`define SPAVG_FMT_DIFF_CM  3'h1
`define SPAVG_FMT_AVG      3'h3
`define SPAVG_FMT_PATTERN  3'h4
// averaging limits and word fields
`define SPAVG_AVG_MAX      5'h10
`define SPAVG_POS_OVR      30
`define SPAVG_POS_SYNC     31
// saturation limits
`define SPAVG_SAT_HI       16'h7fff
`define SPAVG_SAT_LO       16'h8000
// bus responses
`define SPAVG_RESP_OKAY    2'h0
`define SPAVG_RESP_SLVERR  2'h2
`endif

// File: rtl/spavg_scale.v
// per-channel offset, gain and 16-bit saturation stage
`timescale 1ns/1ps
`include "spavg_consts.vh"
module spavg_scale (
    input  wire [15:0] sample_in,    // raw signed differential code
    input  wire [15:0] offset,       // signed offset
    input  wire [15:0] gain,         // unsigned gain, 0x8000 is unity
    output reg  [15:0] sample_out,   // saturated signed result
    output reg         saturated     // result was clamped
);
    reg signed [16:0] sum_s;         // offset-added, one guard bit
    reg signed [33:0] prod_s;        // gain product
    reg signed [18:0] scaled_s;      // product shifted down by 15
    // combinational scaling path
    always @* begin
        sum_s = $signed({sample_in[15], sample_in}) + $signed({offset[15], offset});
        prod_s = sum_s * $signed({1'b0, gain});
        scaled_s = prod_s[33:15];
        if (scaled_s > $signed({3'b000, `SPAVG_SAT_HI})) begin
            sample_out = `SPAVG_SAT_HI;
            saturated  = 1'b1;
        end else if (scaled_s < $signed({3'b111, `SPAVG_SAT_LO})) begin
            sample_out = `SPAVG_SAT_LO;
            saturated  = 1'b1;
        end else begin
            sample_out = scaled_s[15:0];
            saturated  = 1'b0;
        end
    end
endmodule // spavg_scale

// File: rtl/spavg_avg.v
// block averaging filter for one channel
`timescale 1ns/1ps
`include "spavg_consts.vh"
module spavg_avg #(
    parameter ACC_W = 32             // holds 2^16 sums of 16-bit codes
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        sample_valid, // one new scaled sample
    input  wire [15:0] sample,       // scaled signed sample
    input  wire        sample_sat,   // sample was clamped
    input  wire [4:0]  exponent,     // block length exponent
    input  wire        block_last,   // this sample ends the block
    output reg  [31:0] avg_word      // sync, overrange, 30-bit average
);
    reg  [ACC_W-1:0] acc_q;          // running block sum
    reg              ovr_q;          // sticky overrange within block
    wire [ACC_W-1:0] sum_w;          // sum including current sample
    wire             ovr_w;          // overrange including current sample
    wire signed [ACC_W+13:0] shifted_w; // 14 extra bits: sum<<14 must not overflow at N=16
    assign sum_w     = acc_q + {{(ACC_W-16){sample[15]}}, sample};
    assign ovr_w     = ovr_q | sample_sat;
    // sum over 2^N, placed as 16.14
    assign shifted_w = $signed({sum_w, 14'h0000}) >>> exponent;
    ////////////////////////////////////////////////////////////////////////
    // accumulate and emit once per block
    always @(posedge mclk) begin
        if (!rst_n) begin
            acc_q    <= {ACC_W{1'b0}};
            ovr_q    <= 1'b0;
            avg_word <= 32'h00000000;
        end else if (sample_valid) begin
            if (block_last) begin
                acc_q <= {ACC_W{1'b0}};
                ovr_q <= 1'b0;
                avg_word[29:0] <= shifted_w[29:0];
                avg_word[`SPAVG_POS_OVR] <= ovr_w;
                avg_word[`SPAVG_POS_SYNC] <= 1'b1;
            end else begin
                acc_q <= sum_w;
                ovr_q <= ovr_w;
                avg_word[`SPAVG_POS_SYNC] <= 1'b0;
            end
        end
    end
endmodule // spavg_avg

// File: rtl/spavg_top.v
// sample post-processing block with averaging and axi4-lite registers
// Summary of operation
// - average blocks of 2^N, N 1..16
// - clear filter after each block
// - averaging when format 3, N 1..16
// - averaged word 32 bits, 30-bit average
// - constant input repeats in upper 16
// - bit 30 flags saturated block
// - result registers update at strobe over 2^N, output words stop
// - exponent resets to zero
// - per-channel signed 16-bit offset
// - offsets reset to zero
// - per-channel gain over 0x8000
// - gains reset to unity
// - gain overflow saturates, never wraps
// - one test pattern on both channels
// - pattern mode is format 4
// - pattern resets to 0x5a5a0f0f
// - one format for both channels
// - clamp to 0x7fff and 0x8000
// - format 1 appends untouched common-mode
// - differential codes two's complement
`timescale 1ns/1ps
`include "spavg_consts.vh"
module spavg_top (
    input  wire        mclk,
    input  wire        rst_n,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // conversion core
    input  wire        convert_strobe,  // one-cycle: new result pair ready
    input  wire [15:0] ch0_diff,        // channel 0 raw differential code
    input  wire [7:0]  ch0_cm,          // channel 0 common-mode code
    input  wire [15:0] ch1_diff,
    input  wire [7:0]  ch1_cm,
    // output register side
    output reg  [31:0] ch0_word,        // channel 0 output word
    output reg  [31:0] ch1_word,        // channel 1 output word
    output reg         word_valid       // one-cycle: words updated
);
    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    reg  [2:0]  output_format_select;     // shared format selector
    reg  [4:0]  average_length_exponent;  // block length exponent
    reg  [15:0] offset_q [0:1];           // per-channel offsets
    reg  [15:0] channel_gain_factor [0:1];// per-channel gains
    reg  [31:0] pattern_q;                // test pattern
    reg  [16:0] blk_cnt_q;                // samples taken in block
    reg  [31:0] result_q [0:1];           // last emitted words
    // write channel holding
    reg         aw_hold_q;
    reg  [7:0]  aw_addr_q;
    reg         w_hold_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    wire        wr_go;
    wire        ar_go;
    wire [31:0] wmask;
    wire avg_on = (output_format_select == `SPAVG_FMT_AVG) &&
                  (average_length_exponent != 5'h00) &&
                  (average_length_exponent <= `SPAVG_AVG_MAX);
    // with averaging off each sample ends a block
    wire [16:0] blk_len_m1 = (17'h00001 << average_length_exponent) - 17'h00001;
    wire blk_last = !avg_on || (blk_cnt_q == blk_len_m1);
    ////////////////////////////////////////////////////////////////////////
    // per-channel datapath
    wire [15:0] diff_in [0:1];
    wire [7:0]  cm_in   [0:1];
    wire [15:0] scaled  [0:1];
    wire        sat     [0:1];
    wire [31:0] avg_w   [0:1];
    reg  [31:0] word_d  [0:1];
    assign diff_in[0] = ch0_diff;
    assign diff_in[1] = ch1_diff;
    assign cm_in[0]   = ch0_cm;
    assign cm_in[1]   = ch1_cm;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            spavg_scale u_scale (
                .sample_in  (diff_in[gi]),
                .offset     (offset_q[gi]),
                .gain       (channel_gain_factor[gi]),
                .sample_out (scaled[gi]),
                .saturated  (sat[gi])
            );
            spavg_avg u_avg (
                .mclk         (mclk),
                .rst_n        (rst_n),
                .sample_valid (convert_strobe & avg_on),
                .sample       (scaled[gi]),
                .sample_sat   (sat[gi]),
                .exponent     (average_length_exponent),
                .block_last   (blk_last),
                .avg_word     (avg_w[gi])
            );
            always @* begin
                case (output_format_select)
                    `SPAVG_FMT_DIFF_CM: begin
                        word_d[gi] = {8'h00, scaled[gi], cm_in[gi]};
                    end
                    `SPAVG_FMT_PATTERN: begin
                        word_d[gi] = pattern_q;
                    end
                    default: begin
                        word_d[gi] = {16'h0000, scaled[gi]};
                    end
                endcase
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // block counter and output words
    always @(posedge mclk) begin
        if (!rst_n) begin
            blk_cnt_q  <= 17'h00000;
            ch0_word   <= 32'h00000000;
            ch1_word   <= 32'h00000000;
            word_valid <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (!avg_on) begin
                // restart block count while averaging is off; filter sum is kept
                blk_cnt_q <= 17'h00000;
            end else if (convert_strobe) begin
                blk_cnt_q <= blk_last ? 17'h00000 : blk_cnt_q + 17'h00001;
            end
            if (convert_strobe && !avg_on) begin
                ch0_word   <= word_d[0];
                ch1_word   <= word_d[1];
                word_valid <= 1'b1;
            end
        end
    end
    // averages land one cycle after the block
    reg avg_emit_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            avg_emit_q <= 1'b0;
        end else begin
            avg_emit_q <= convert_strobe && avg_on && blk_last;
        end
    end
    // result capture, averages first
    always @(posedge mclk) begin
        if (!rst_n) begin
            result_q[0] <= 32'h00000000;
            result_q[1] <= 32'h00000000;
        end else if (avg_emit_q) begin
            result_q[0] <= avg_w[0];
            result_q[1] <= avg_w[1];
        end else if (word_valid) begin
            result_q[0] <= ch0_word;
            result_q[1] <= ch1_word;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write path, either order
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    // register writes and write response
    always @(posedge mclk) begin
        if (!rst_n) begin
            aw_hold_q    <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_hold_q     <= 1'b0;
            w_data_q     <= 32'h00000000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SPAVG_RESP_OKAY;
            output_format_select    <= `SPAVG_RST_FORMAT;
            average_length_exponent <= `SPAVG_RST_AVGEXP;
            offset_q[0] <= `SPAVG_RST_OFFSET;
            offset_q[1] <= `SPAVG_RST_OFFSET;
            channel_gain_factor[0] <= `SPAVG_RST_GAIN;
            channel_gain_factor[1] <= `SPAVG_RST_GAIN;
            pattern_q <= `SPAVG_RST_PATTERN;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `SPAVG_RESP_OKAY;
                case ({aw_addr_q[7:2], 2'b00})
                    `SPAVG_OFS_FORMAT:
                        output_format_select <= (w_data_q[2:0] & wmask[2:0]) |
                                                (output_format_select & ~wmask[2:0]);
                    `SPAVG_OFS_AVGEXP:
                        average_length_exponent <= (w_data_q[4:0] & wmask[4:0]) |
                                                   (average_length_exponent & ~wmask[4:0]);
                    `SPAVG_OFS_OFFSET0:
                        offset_q[0] <= (w_data_q[15:0] & wmask[15:0]) |
                                       (offset_q[0] & ~wmask[15:0]);
                    `SPAVG_OFS_OFFSET1:
                        offset_q[1] <= (w_data_q[15:0] & wmask[15:0]) |
                                       (offset_q[1] & ~wmask[15:0]);
                    `SPAVG_OFS_GAIN0:
                        channel_gain_factor[0] <= (w_data_q[15:0] & wmask[15:0]) |
                                                  (channel_gain_factor[0] & ~wmask[15:0]);
                    `SPAVG_OFS_GAIN1:
                        channel_gain_factor[1] <= (w_data_q[15:0] & wmask[15:0]) |
                                                  (channel_gain_factor[1] & ~wmask[15:0]);
                    `SPAVG_OFS_PATTERN:
                        pattern_q <= (w_data_q & wmask) | (pattern_q & ~wmask);
                    `SPAVG_OFS_STATUS, `SPAVG_OFS_RESULT0, `SPAVG_OFS_RESULT1: begin
                        // read-only: ignored, still okay
                        s_axi_bresp <= `SPAVG_RESP_OKAY;
                    end
                    default: begin
                        // unmapped address
                        s_axi_bresp <= `SPAVG_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read path, answer next cycle
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_go = s_axi_arvalid && s_axi_arready;
    always @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `SPAVG_RESP_OKAY;
        end else if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SPAVG_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `SPAVG_OFS_FORMAT:  s_axi_rdata <= {29'h0, output_format_select};
                `SPAVG_OFS_AVGEXP:  s_axi_rdata <= {27'h0, average_length_exponent};
                `SPAVG_OFS_OFFSET0: s_axi_rdata <= {16'h0, offset_q[0]};
                `SPAVG_OFS_OFFSET1: s_axi_rdata <= {16'h0, offset_q[1]};
                `SPAVG_OFS_GAIN0:   s_axi_rdata <= {16'h0, channel_gain_factor[0]};
                `SPAVG_OFS_GAIN1:   s_axi_rdata <= {16'h0, channel_gain_factor[1]};
                `SPAVG_OFS_PATTERN: s_axi_rdata <= pattern_q;
                // status: averaging active and block position
                `SPAVG_OFS_STATUS:  s_axi_rdata <= {14'h0, avg_on, blk_cnt_q};
                `SPAVG_OFS_RESULT0: s_axi_rdata <= result_q[0];
                `SPAVG_OFS_RESULT1: s_axi_rdata <= result_q[1];
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `SPAVG_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // spavg_top

// File: sim/spavg_properties.sv
// concurrent checks on the ports of the post-processing block
`timescale 1ns/1ps
`include "spavg_consts.vh"
module spavg_checker (
    input wire        mclk,
    input wire        rst_n,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        convert_strobe,
    input wire [15:0] ch0_diff,
    input wire [7:0]  ch0_cm,
    input wire [7:0]  ch1_cm,
    input wire [31:0] ch0_word,
    input wire [31:0] ch1_word,
    input wire        word_valid
);
    ////////////////////////////////////////////////////////////////////////////
    reg  [2:0]  fmt_q;   // shadow format selector
    reg  [4:0]  exp_q;   // shadow block exponent
    reg  [15:0] off0_q;  // shadow channel 0 offset
    reg  [15:0] gain0_q; // shadow channel 0 gain
    reg  [31:0] pat_q;   // shadow test pattern
    // full words only
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire avg_on = fmt_q == `SPAVG_FMT_AVG && exp_q != 5'h00 && exp_q <= `SPAVG_AVG_MAX;
    wire plain0 = word_valid && fmt_q == `SPAVG_FMT_DIFF;
    // shadows follow accepted writes
    always @(posedge mclk) begin
        if (!rst_n) begin
            fmt_q   <= `SPAVG_RST_FORMAT;
            exp_q   <= `SPAVG_RST_AVGEXP;
            off0_q  <= `SPAVG_RST_OFFSET;
            gain0_q <= `SPAVG_RST_GAIN;
            pat_q   <= `SPAVG_RST_PATTERN;
        end else if (wr_go) begin
            case (s_axi_awaddr)
                `SPAVG_OFS_FORMAT:  fmt_q   <= s_axi_wdata[2:0];
                `SPAVG_OFS_AVGEXP:  exp_q   <= s_axi_wdata[4:0];
                `SPAVG_OFS_OFFSET0: off0_q  <= s_axi_wdata[15:0];
                `SPAVG_OFS_GAIN0:   gain0_q <= s_axi_wdata[15:0];
                `SPAVG_OFS_PATTERN: pat_q   <= s_axi_wdata;
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_cause; word_valid |-> $past(convert_strobe); endproperty
    a_cause: assert property (p_cause)
        else $error("word without strobe");
    property p_rate; convert_strobe && !avg_on |=> word_valid; endproperty
    a_rate: assert property (p_rate)
        else $error("strobe gave no word");
    property p_quiet; convert_strobe && avg_on |=> !word_valid; endproperty
    a_quiet: assert property (p_quiet)
        else $error("word while averaging");
    property p_pat;
        word_valid && fmt_q == `SPAVG_FMT_PATTERN |-> ch0_word == pat_q && ch1_word == pat_q;
    endproperty
    a_pat: assert property (p_pat)
        else $error("pattern word mismatch");
    property p_diff; plain0 |-> ch0_word[31:16] == 16'h0000 && ch1_word[31:16] == 16'h0000;
    endproperty
    a_diff: assert property (p_diff)
        else $error("plain upper half set");
    property p_cm;
        word_valid && fmt_q == `SPAVG_FMT_DIFF_CM |-> ch0_word[7:0] == $past(ch0_cm)
            && ch1_word[7:0] == $past(ch1_cm) && ch0_word[31:24] == 8'h00;
    endproperty
    a_cm: assert property (p_cm)
        else $error("common-mode code altered");
    property p_unity;
        plain0 && off0_q == `SPAVG_RST_OFFSET && gain0_q == `SPAVG_RST_GAIN
            |-> ch0_word[15:0] == $past(ch0_diff);
    endproperty
    a_unity: assert property (p_unity)
        else $error("unity gain changed the code");
    property p_clamp;
        plain0 && !off0_q[15] && gain0_q[15] && $past(ch0_diff) == `SPAVG_SAT_HI
            |-> ch0_word[15:0] == `SPAVG_SAT_HI;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("high clamp missed");
    c_pat: cover property (word_valid && fmt_q == `SPAVG_FMT_PATTERN);
    c_cm: cover property (word_valid && fmt_q == `SPAVG_FMT_DIFF_CM);
    c_avg: cover property (convert_strobe && avg_on);
endmodule // spavg_checker
bind spavg_top spavg_checker chk_u (.*);

// File: sim/spavg_host_model.sv
// host side model capturing per-sample output words
`timescale 1ns/1ps
module spavg_host_model (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        word_valid,
    input  wire [31:0] ch0_word,
    input  wire [31:0] ch1_word,
    output reg  [31:0] last0,
    output reg  [31:0] last1,
    output reg  [31:0] n_words
);
    // count pairs so a stale one is caught
    always @(posedge mclk) begin
        if (!rst_n) begin
            n_words <= 32'h0;
        end else if (word_valid) begin
            last0   <= ch0_word;
            last1   <= ch1_word;
            n_words <= n_words + 32'h1;
        end
    end
endmodule // spavg_host_model

// File: sim/test_sample_postprocess_averager.sv
// self-checking bench for the sample post-processing block
`timescale 1ns/1ps
`include "spavg_consts.vh"
module test_sample_postprocess_averager;
    logic        mclk = 1'b0, rst_n = 1'b0, convert_strobe = 1'b0, word_valid;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_bvalid;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid, s_axi_arready;
    logic        s_axi_awready, s_axi_wready;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ch0_cm = 8'h00, ch1_cm = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ch0_word, ch1_word, last0, last1, n_words;
    logic [15:0] ch0_diff = 16'h0, ch1_diff = 16'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          n_fail = 0, compares = 0, cycles = 0;
    logic [31:0] seed = 32'h44, rd, r, pat = `SPAVG_RST_PATTERN; // xorshift starts at 68
    logic [2:0]  fmt = `SPAVG_FMT_DIFF; // shadow selector
    logic [15:0] off [2] = '{16'h0, 16'h0};
    logic [15:0] gain [2] = '{`SPAVG_RST_GAIN, `SPAVG_RST_GAIN};
    logic [31:0] rst_tab [7] = '{0, 0, 0, 0, 32'h8000, 32'h8000, `SPAVG_RST_PATTERN};
    spavg_top dut_u (.*, .s_axi_wstrb(4'hf));
    spavg_host_model host_u (.*);
    ////////////////////////////////////////////////////////////////////////////
    always #50 mclk = ~mclk;
    // hang guard, longest block is 65536 strobes
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_fail++;
            stop_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // offset, gain, floor, clamp; bit 16 flags a clamp
    function automatic logic [16:0] exp_scale(input logic [15:0] x, o, g);
        longint v;
        v = (longint'($signed(x)) + longint'($signed(o))) * longint'({1'b0, g}) >>> 15;
        if (v > 32767) return {1'b1, `SPAVG_SAT_HI};
        if (v < -32768) return {1'b1, `SPAVG_SAT_LO};
        return {1'b0, v[15:0]};
    endfunction
    function automatic logic [31:0] exp_word(input logic [15:0] d, input logic [7:0] cm, int c);
        logic [16:0] s;
        s = exp_scale(d, off[c], gain[c]);
        if (fmt == `SPAVG_FMT_PATTERN) return pat;
        if (fmt == `SPAVG_FMT_DIFF_CM) return {8'h00, s[15:0], cm};
        return {16'h0000, s[15:0]};
    endfunction
    task automatic check(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // bus tasks: enter after an edge
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        if (a == `SPAVG_OFS_FORMAT) fmt = d[2:0];
        if (a == `SPAVG_OFS_PATTERN) pat = d;
        if (a == `SPAVG_OFS_OFFSET0 || a == `SPAVG_OFS_OFFSET1) off[a[2]] = d[15:0];
        if (a == `SPAVG_OFS_GAIN0 || a == `SPAVG_OFS_GAIN1) gain[a[2]] = d[15:0];
        @(posedge mclk);
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    // one strobe, pair compared
    task automatic sample(input logic [31:0] w);
        logic [31:0] cm, nw;
        cm = rnd();
        nw = n_words;
        convert_strobe <= 1'b1;
        ch0_diff <= w[15:0];
        ch1_diff <= w[31:16];
        ch0_cm <= cm[7:0];
        ch1_cm <= cm[15:8];
        @(posedge mclk);
        convert_strobe <= 1'b0;
        ch0_diff <= ~w[15:0];
        ch1_diff <= ~w[31:16];
        repeat (2) @(posedge mclk);
        check(n_words, nw + 32'h1);
        check(last0, exp_word(w[15:0], cm[7:0], 0));
        check(last1, exp_word(w[31:16], cm[15:8], 1));
    endtask
    // one block of strobes, results read
    task automatic avg_block(input int n, input logic cst);
        longint sum [2], v;
        logic [1:0] ovr;
        logic [16:0] s;
        sum = '{0, 0};
        ovr = 2'b00;
        r = rnd();
        for (int i = 0; i < (1 << n); i++) begin
            if (!cst) r = rnd();
            convert_strobe <= 1'b1;
            ch0_diff <= r[15:0];
            ch1_diff <= r[31:16];
            for (int c = 0; c < 2; c++) begin
                s = exp_scale(r[16 * c +: 16], off[c], gain[c]);
                sum[c] += longint'($signed(s[15:0]));
                ovr[c] = ovr[c] | s[16];
            end
            @(posedge mclk);
        end
        convert_strobe <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int c = 0; c < 2; c++) begin
            reg_read(`SPAVG_OFS_RESULT0 + 8'(4 * c), rd);
            v = n > 14 ? sum[c] >>> (n - 14) : sum[c] <<< (14 - n);
            check(rd, {1'b1, ovr[c], v[29:0]});
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 7; i++) begin
            reg_read(8'(4 * i), rd);
            check(rd, rst_tab[i]);
        end
        reg_read(8'h40, rd);
        check({rd[29:0], rs}, {30'h0, `SPAVG_RESP_SLVERR});
        // g0 reset, g1 clamp corners, then random
        for (int g = 0; g < 4; g++) begin
            if (g > 0) begin
                r = rnd();
                reg_write(`SPAVG_OFS_OFFSET0, g == 1 ? 32'h0100 : {16'h0, r[15:0]});
                reg_write(`SPAVG_OFS_GAIN0, g == 1 ? 32'hffff : {16'h0, r[31:16]});
                r = rnd();
                reg_write(`SPAVG_OFS_OFFSET1, g == 1 ? 32'h8000 : {16'h0, r[15:0]});
                reg_write(`SPAVG_OFS_GAIN1, g == 1 ? 32'hffff : {16'h0, r[31:16]});
            end
            for (int k = 0; k < 8; k++) begin
                r = k > 1 ? rnd() : (k == 1 ? 32'h80007fff : 32'h7fff8000);
                sample(r);
            end
        end
        reg_write(`SPAVG_OFS_FORMAT, 32'h1);
        repeat (4) sample(rnd());
        reg_write(`SPAVG_OFS_PATTERN, rnd());
        reg_write(`SPAVG_OFS_FORMAT, 32'h4);
        repeat (3) sample(rnd());
        reg_write(`SPAVG_OFS_FORMAT, 32'h3);
        repeat (3) sample(rnd());
        reg_write(`SPAVG_OFS_AVGEXP, 32'h11);
        repeat (3) sample(rnd());
        reg_write(`SPAVG_OFS_AVGEXP, 32'h2);
        avg_block(2, 1'b0);
        avg_block(2, 1'b0);
        reg_write(`SPAVG_OFS_AVGEXP, 32'h4);
        avg_block(4, 1'b0);
        reg_write(`SPAVG_OFS_AVGEXP, 32'h10);
        avg_block(16, 1'b1);
        stop_test();
    end
endmodule // test_sample_postprocess_averager
